// ### include/thermal_status_pkg.sv
// Constants, register map and carrier types for the thermal status and alert block.
// Assumes a register access port driven by a bus front end on the system clock.
// Operation
// - Monitoring cycle starts at power-up, or when the enable bit is written to one.
// - Cycle repeats until the enable bit, bit 0 of config one, is written zero.
// - Each channel converts in turn; its value register updates when conversion ends.
// - With averaging, local conversion takes 11 ms and each remote 32 ms.
// - After the full cycle period elapses, a new pass starts from the local channel.
// - Fan tachometer sampling runs free, unsynchronised to the temperature sequence.
// - Limit results live in status registers 0x4F to 0x51; one means out of limit.
// - Set bits stay set; clear on read when in limit, or on an alert response.
// - Masks only block the alert output; status bits still set.
// - Status one bits 7 to 0: local hi, lo; remote one hi, lo, fault; remote two same.
// - Diode fault flags set on open or short; remote one bit 3, two bit 0.
// - Status two bits 7..5 overtemperature per channel, bit 4 on-time limit, 1:0 reserved.
// - Status two bit 3 set when an overtemp limit is exceeded and output asserted.
// - Status two bit 2 shows overtemp pin active; read clears only if inactive.
// - Status three: fan one stall bit 7, alarm speed bit 6, fan two stall bit 5.
// - Status three bit 0 is one whenever the alert line is driven low.
// - Alert asserts whenever an unmasked source is out of limit; in comparator mode status two bit 2 does not.
// - Config one bit 3 selects alert mode: zero latched, one comparator.
// - Latched alert stays low until read or response clears it and nothing remains.
// - Comparator alert releases automatically once no source remains out of limit.
// - High violation when value is at or above limit; low when strictly below.
// - At slow rates value registers hold the average of 16 measurements.
package thermal_status_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_ONE_ADDR    = 8'h01;
  localparam logic [7:0] MASK_ONE_ADDR      = 8'h08;
  localparam logic [7:0] MASK_TWO_ADDR      = 8'h09;
  localparam logic [7:0] MASK_THREE_ADDR    = 8'h0a;
  localparam logic [7:0] LIMIT_BASE_ADDR    = 8'h0b;
  localparam logic [7:0] LOCAL_VALUE_ADDR   = 8'h20;
  localparam logic [7:0] REMOTE1_VALUE_ADDR = 8'h21;
  localparam logic [7:0] REMOTE2_VALUE_ADDR = 8'h22;
  localparam logic [7:0] TEMP_FLAGS_ADDR    = 8'h4f;
  localparam logic [7:0] OVERTEMP_FLAGS_ADDR = 8'h50;
  localparam logic [7:0] FAN_FLAGS_ADDR     = 8'h51;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MONITOR_ENABLE_POS  = 0;
  localparam int AVERAGING_DIS_POS   = 1;
  localparam int ALERT_MODE_POS      = 3;
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h01;
  localparam logic [7:0] MASK_RESET       = 8'h00;
  localparam logic [7:0] HIGH_LIMIT_RESET = 8'h8b;
  localparam logic [7:0] LOW_LIMIT_RESET  = 8'h54;
  localparam logic [7:0] OT_LIMIT_RESET   = 8'h95;
  localparam logic [7:0] MASK_TWO_VALID   = 8'h1c;
  localparam logic [7:0] MASK_THREE_VALID = 8'he0;
  localparam int AVERAGE_COUNT = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int LOCAL_CONV_MS    = 11;
  localparam int REMOTE_CONV_MS   = 32;
  localparam int LOCAL_CONV_CYC   = LOCAL_CONV_MS * 1000 * CLK_MHZ;
  localparam int REMOTE_CONV_CYC  = REMOTE_CONV_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SEQ_IDLE    = 4'b0001,
    SEQ_LOCAL   = 4'b0010,
    SEQ_REMOTE1 = 4'b0100,
    SEQ_REMOTE2 = 4'b1000
  } seq_state_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] value;
    logic       diode_fault;
  } conv_result_t;

endpackage : thermal_status_pkg

// ### logic/thermal_status_alert_logic.sv
// Status, sequencing and alert logic of the thermal monitor.
// Assumes a register front end on i_clk, a converter answering each start,
// and fan tachometer pins on their own clock domain.
`timescale 1ns/1ps
module thermal_status_alert_logic #(
  parameter int LOCAL_CYCLES  = thermal_status_pkg::LOCAL_CONV_CYC,
  parameter int REMOTE_CYCLES = thermal_status_pkg::REMOTE_CONV_CYC,
  parameter int FAN_A_TIMEOUT  = 4096
) (
  // System
  input  wire logic                             i_clk,
  input  wire logic                             i_sys_rst,
  // Register access
  input  wire thermal_status_pkg::reg_req_t     i_req,
  output logic [7:0]                            o_rdata,
  output logic                                  o_rvalid,
  input  wire logic                             i_alert_response_done,
  // Converter
  output logic [2:0]                            o_conv_start,
  output logic                                  o_conv_average,
  input  wire logic                             i_conv_done,
  input  wire thermal_status_pkg::conv_result_t i_conv_result,
  // Overtemperature and fan status
  input  wire logic                             i_overtemp_pin,
  input  wire logic                             i_overtemp_pct_exceeded,
  input  wire logic                             i_fan_alarm_speed,
  // Fan tachometer domain
  input  wire logic                             i_fan_a_clk,
  input  wire logic                             i_fan_a_rst,
  input  wire logic                             i_fan_a,
  input  wire logic                             i_fan_b,
  // Alert
  output logic                                  o_alert_n,
  output logic                                  o_alert_oe
);

  // ----------------------------------------------------------------
  // Configuration and limit registers
  // ----------------------------------------------------------------
  logic [7:0] config_reg;
  logic [7:0] mask_one_reg;
  logic [7:0] mask_two_reg;
  logic [7:0] mask_three_reg;
  logic [7:0] limit_reg [9];
  logic [7:0] value_reg [3];

  wire wr_config = i_req.wr && (i_req.addr == thermal_status_pkg::CONFIG_ONE_ADDR);
  wire wr_mask1  = i_req.wr && (i_req.addr == thermal_status_pkg::MASK_ONE_ADDR);
  wire wr_mask2  = i_req.wr && (i_req.addr == thermal_status_pkg::MASK_TWO_ADDR);
  wire wr_mask3  = i_req.wr && (i_req.addr == thermal_status_pkg::MASK_THREE_ADDR);
  wire monitor_en = config_reg[thermal_status_pkg::MONITOR_ENABLE_POS];
  wire comp_mode  = config_reg[thermal_status_pkg::ALERT_MODE_POS];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      config_reg     <= thermal_status_pkg::CONFIG_ONE_RESET;
      mask_one_reg   <= thermal_status_pkg::MASK_RESET;
      mask_two_reg   <= thermal_status_pkg::MASK_RESET;
      mask_three_reg <= thermal_status_pkg::MASK_RESET;
    end else begin
      if (wr_config) config_reg <= i_req.wdata;
      if (wr_mask1) mask_one_reg <= i_req.wdata;
      if (wr_mask2) mask_two_reg <= i_req.wdata & thermal_status_pkg::MASK_TWO_VALID;
      if (wr_mask3) mask_three_reg <= i_req.wdata & thermal_status_pkg::MASK_THREE_VALID;
    end
  end

  // Limits: high, low, overtemp per channel
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_limit
      localparam logic [7:0] LIM_RST = (gi % 3 == 0) ? thermal_status_pkg::HIGH_LIMIT_RESET :
                                       (gi % 3 == 1) ? thermal_status_pkg::LOW_LIMIT_RESET :
                                                       thermal_status_pkg::OT_LIMIT_RESET;
      wire wr_lim = i_req.wr &&
                    (i_req.addr == thermal_status_pkg::LIMIT_BASE_ADDR + 8'(gi));
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) limit_reg[gi] <= LIM_RST;
        else if (wr_lim) limit_reg[gi] <= i_req.wdata;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Round-robin sequencer
  // ----------------------------------------------------------------
  thermal_status_pkg::seq_state_t seq_reg, seq_next;
  logic [31:0] slot_cnt_reg;
  logic [31:0] slot_len;
  logic [2:0]  start_reg;

  assign slot_len = (seq_reg == thermal_status_pkg::SEQ_LOCAL) ? 32'(LOCAL_CYCLES)
                                                               : 32'(REMOTE_CYCLES);
  wire slot_end = (slot_cnt_reg == slot_len - 32'h0000_0001);

  always_comb begin
    seq_next = seq_reg;
    unique case (seq_reg)
      thermal_status_pkg::SEQ_IDLE:    if (monitor_en) seq_next = thermal_status_pkg::SEQ_LOCAL;
      thermal_status_pkg::SEQ_LOCAL:   if (slot_end) seq_next = thermal_status_pkg::SEQ_REMOTE1;
      thermal_status_pkg::SEQ_REMOTE1: if (slot_end) seq_next = thermal_status_pkg::SEQ_REMOTE2;
      thermal_status_pkg::SEQ_REMOTE2: if (slot_end) seq_next = monitor_en ?
                                         thermal_status_pkg::SEQ_LOCAL :
                                         thermal_status_pkg::SEQ_IDLE;
      default: seq_next = thermal_status_pkg::SEQ_IDLE;
    endcase
  end

  wire entering = (seq_next != seq_reg) && (seq_next != thermal_status_pkg::SEQ_IDLE);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      seq_reg      <= thermal_status_pkg::SEQ_IDLE;
      slot_cnt_reg <= 32'h0000_0000;
      start_reg    <= 3'h0;
    end else begin
      seq_reg      <= seq_next;
      slot_cnt_reg <= (entering || seq_reg == thermal_status_pkg::SEQ_IDLE) ? 32'h0000_0000
                                                            : slot_cnt_reg + 32'h0000_0001;
      start_reg    <= entering ? seq_next[3:1] : 3'h0;
    end
  end

  assign o_conv_start   = start_reg;
  assign o_conv_average = ~config_reg[thermal_status_pkg::AVERAGING_DIS_POS];

  // Channel whose conversion is in flight
  wire [1:0] cur_ch = seq_reg[2] ? 2'd1 : (seq_reg[3] ? 2'd2 : 2'd0);

  // ----------------------------------------------------------------
  // Value registers and limit comparisons
  // ----------------------------------------------------------------
  logic [2:0] high_cond;
  logic [2:0] low_cond;
  logic [2:0] ot_cond;
  logic [2:0] diode_cond_reg;
  logic [2:0] conv_valid_reg;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      wire take = i_conv_done && (cur_ch == 2'(gi)) && (seq_reg != thermal_status_pkg::SEQ_IDLE);
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          value_reg[gi]      <= 8'h00;
          diode_cond_reg[gi] <= 1'b0;
          conv_valid_reg[gi] <= 1'b0;
        end else if (take) begin
          value_reg[gi]      <= i_conv_result.value;
          diode_cond_reg[gi] <= i_conv_result.diode_fault;
          conv_valid_reg[gi] <= 1'b1;
        end
      end
      assign high_cond[gi] = value_reg[gi] >= limit_reg[3*gi];
      assign low_cond[gi]  = value_reg[gi] <  limit_reg[3*gi + 1];
      assign ot_cond[gi]   = value_reg[gi] >= limit_reg[3*gi + 2];
    end
  endgenerate

  // A channel compares only once converted: value registers reset to zero,
  // which would otherwise raise every low flag at power-up
  wire [2:0] high_live = high_cond & conv_valid_reg;
  wire [2:0] low_live  = low_cond & conv_valid_reg;
  wire [2:0] ot_live   = ot_cond & conv_valid_reg;

  // ----------------------------------------------------------------
  // Fan tachometer domain: stall detect runs free of the sequencer
  // ----------------------------------------------------------------
  logic [1:0] fan_a_s1_reg, fan_a_s2_reg, fan_a_s3_reg;
  logic [1:0] stall_fan_a_reg;
  logic [12:0] fan_a_cnt_reg [2];

  always_ff @(posedge i_fan_a_clk) begin
    if (i_fan_a_rst) begin
      fan_a_s1_reg <= 2'h0;
      fan_a_s2_reg <= 2'h0;
      fan_a_s3_reg <= 2'h0;
    end else begin
      fan_a_s1_reg <= {i_fan_b, i_fan_a};
      fan_a_s2_reg <= fan_a_s1_reg;
      fan_a_s3_reg <= fan_a_s2_reg;
    end
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_fan
      wire edge_seen = fan_a_s2_reg[gi] ^ fan_a_s3_reg[gi];
      always_ff @(posedge i_fan_a_clk) begin
        if (i_fan_a_rst) begin
          fan_a_cnt_reg[gi]   <= 13'h0000;
          stall_fan_a_reg[gi] <= 1'b0;
        end else if (edge_seen) begin
          fan_a_cnt_reg[gi]   <= 13'h0000;
          stall_fan_a_reg[gi] <= 1'b0;
        end else if (fan_a_cnt_reg[gi] == 13'(FAN_A_TIMEOUT)) begin
          stall_fan_a_reg[gi] <= 1'b1;
        end else begin
          fan_a_cnt_reg[gi]   <= fan_a_cnt_reg[gi] + 13'h0001;
        end
      end
    end
  endgenerate

  // Level crossings into the system domain
  logic [1:0] stall_s1_reg, stall_s2_reg;
  logic       ot_s1_reg, ot_s2_reg;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      stall_s1_reg <= 2'h0;
      stall_s2_reg <= 2'h0;
      ot_s1_reg    <= 1'b0;
      ot_s2_reg    <= 1'b0;
    end else begin
      stall_s1_reg <= stall_fan_a_reg;
      stall_s2_reg <= stall_s1_reg;
      ot_s1_reg    <= i_overtemp_pin;
      ot_s2_reg    <= ot_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Sticky status registers
  // ----------------------------------------------------------------
  logic [7:0] temp_flags_reg, temp_flags_next;
  logic [7:0] ot_flags_reg, ot_flags_next;
  logic [7:0] fan_flags_reg, fan_flags_next;
  logic       alert_low_reg, alert_low_next;

  wire [7:0] temp_cond = {high_live[0], low_live[0], high_live[1], low_live[1],
                          diode_cond_reg[1], high_live[2], low_live[2],
                          diode_cond_reg[2]};
  wire       ot_any    = |ot_live;
  wire [7:0] ot_cond_v = {ot_live[0], ot_live[1], ot_live[2], i_overtemp_pct_exceeded,
                          ot_any && ot_s2_reg, ot_s2_reg, 2'b00};
  wire [7:0] fan_cond  = {stall_s2_reg[0], i_fan_alarm_speed, stall_s2_reg[1], 5'h00};

  wire rd_temp = i_req.rd && (i_req.addr == thermal_status_pkg::TEMP_FLAGS_ADDR);
  wire rd_ot   = i_req.rd && (i_req.addr == thermal_status_pkg::OVERTEMP_FLAGS_ADDR);
  wire rd_fan  = i_req.rd && (i_req.addr == thermal_status_pkg::FAN_FLAGS_ADDR);
  wire ack     = i_alert_response_done;

  // Set wins over clear: a clear only drops bits whose condition is gone
  assign temp_flags_next = temp_cond | (temp_flags_reg & ~((rd_temp || ack) ? 8'hff : 8'h00));
  assign ot_flags_next   = ot_cond_v | (ot_flags_reg & ~((rd_ot || ack) ? 8'hff : 8'h00));
  assign fan_flags_next  = fan_cond | (fan_flags_reg & ~((rd_fan || ack) ? 8'he0 : 8'h00));

  // Pin-state bit never raises the alert in comparator mode
  wire [7:0] ot_alert_mask = comp_mode ? (mask_two_reg | 8'h04) : mask_two_reg;
  wire src_flags = |(temp_flags_next & ~mask_one_reg) | |(ot_flags_next & ~ot_alert_mask) |
                   |(fan_flags_next[7:5] & ~mask_three_reg[7:5]);
  wire src_live  = |(temp_cond & ~mask_one_reg) | |(ot_cond_v & ~ot_alert_mask) |
                   |(fan_cond[7:5] & ~mask_three_reg[7:5]);
  assign alert_low_next = comp_mode ? src_live : src_flags;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      temp_flags_reg <= 8'h00;
      ot_flags_reg   <= 8'h00;
      fan_flags_reg  <= 8'h00;
      alert_low_reg  <= 1'b0;
    end else begin
      temp_flags_reg <= temp_flags_next;
      ot_flags_reg   <= ot_flags_next;
      fan_flags_reg  <= fan_flags_next;
      alert_low_reg  <= alert_low_next;
    end
  end

  assign o_alert_n  = ~alert_low_reg;
  assign o_alert_oe = alert_low_reg; // Open drain: drive only when low

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic       rvalid_reg;
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (i_req.addr)
      thermal_status_pkg::CONFIG_ONE_ADDR:     rd_mux = config_reg;
      thermal_status_pkg::MASK_ONE_ADDR:       rd_mux = mask_one_reg;
      thermal_status_pkg::MASK_TWO_ADDR:       rd_mux = mask_two_reg;
      thermal_status_pkg::MASK_THREE_ADDR:     rd_mux = mask_three_reg;
      thermal_status_pkg::LOCAL_VALUE_ADDR:    rd_mux = value_reg[0];
      thermal_status_pkg::REMOTE1_VALUE_ADDR:  rd_mux = value_reg[1];
      thermal_status_pkg::REMOTE2_VALUE_ADDR:  rd_mux = value_reg[2];
      thermal_status_pkg::TEMP_FLAGS_ADDR:     rd_mux = temp_flags_reg;
      thermal_status_pkg::OVERTEMP_FLAGS_ADDR: rd_mux = {ot_flags_reg[7:2], 2'b00};
      thermal_status_pkg::FAN_FLAGS_ADDR:      rd_mux = {fan_flags_reg[7:5], 4'h0,
                                                         alert_low_reg};
      default: begin
        if (i_req.addr >= thermal_status_pkg::LIMIT_BASE_ADDR &&
            i_req.addr < thermal_status_pkg::LIMIT_BASE_ADDR + 8'h09)
          rd_mux = limit_reg[4'(i_req.addr - thermal_status_pkg::LIMIT_BASE_ADDR)];
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rd_mux;
      rvalid_reg <= i_req.rd;
    end
  end
  assign o_rdata  = rdata_reg;
  assign o_rvalid = rvalid_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  flag_sticky_a: assert property (temp_flags_reg[7] && !rd_temp && !ack |=> temp_flags_reg[7])
    else $error("temperature flag dropped without a clear");
  flag_sets_a: assert property (temp_cond[3] |=> temp_flags_reg[3])
    else $error("diode fault did not set flag");
  mask_status_a: assert property (mask_one_reg[6] && temp_cond[6] |=> temp_flags_reg[6])
    else $error("masked source did not set status");
  alert_bit_a: assert property (rd_fan |=> rdata_reg[0] == $past(alert_low_reg))
    else $error("alert-low bit disagrees with pin");
  comp_release_a: assert property (comp_mode && !src_live && $stable(comp_mode) |=> o_alert_n)
    else $error("comparator alert did not release");
  latched_hold_a: assert property (!comp_mode && !o_alert_n && !rd_temp && !rd_ot && !rd_fan
                                   && !ack && $stable(mask_one_reg) && $stable(mask_two_reg)
                                   && $stable(mask_three_reg) && !wr_config |=> !o_alert_n)
    else $error("latched alert released without software");
  high_cmp_a: assert property (value_reg[0] == limit_reg[0] |-> high_cond[0])
    else $error("high compare not inclusive");
  low_cmp_a: assert property (value_reg[0] == limit_reg[1] |-> !low_cond[0])
    else $error("low compare not strict");
  standby_a: assert property (seq_reg == thermal_status_pkg::SEQ_REMOTE2 && slot_end && !monitor_en
                              |=> seq_reg == thermal_status_pkg::SEQ_IDLE)
    else $error("sequencer did not enter standby");
  restart_a: assert property (seq_reg == thermal_status_pkg::SEQ_REMOTE2 && slot_end && monitor_en
                              |=> seq_reg == thermal_status_pkg::SEQ_LOCAL && start_reg == 3'h1
                              ##1 start_reg == 3'h0)
    else $error("round robin did not restart");
  pin_bit_a: assert property (ot_s2_reg |=> ot_flags_reg[2])
    else $error("overtemp pin state not flagged");

  // Sequencing, read-port and alert checks
  start_onehot_a: assert property ($onehot0(start_reg))
    else $error("more than one conversion started");
  value_take_a: assert property (i_conv_done && seq_reg == thermal_status_pkg::SEQ_LOCAL
                                 |=> value_reg[0] == $past(i_conv_result.value))
    else $error("local value not stored");
  standby_idle_a: assert property (seq_reg == thermal_status_pkg::SEQ_IDLE && !monitor_en
                                   |=> o_conv_start == 3'h0)
    else $error("conversion started in standby");
  monitor_start_a: assert property (seq_reg == thermal_status_pkg::SEQ_IDLE && monitor_en
                                    |=> o_conv_start == 3'h1)
    else $error("monitoring did not start");
  read_clears_a: assert property (rd_temp && temp_cond == 8'h00
                                  |=> temp_flags_reg == 8'h00)
    else $error("read left an ended flag set");
  latched_set_a: assert property (!comp_mode && |(temp_cond & ~mask_one_reg)
                                  |=> !o_alert_n)
    else $error("unmasked source did not pull alert low");
  comp_alert_a: assert property (comp_mode && src_live |=> !o_alert_n)
    else $error("comparator alert not pulled low");
  rvalid_follow_a: assert property (i_req.rd |=> o_rvalid)
    else $error("read answer missing");

  cov_latched_c: cover property (!comp_mode && !o_alert_n ##1 ack ##1 o_alert_n);
  cov_comp_c: cover property (comp_mode && !o_alert_n ##1 o_alert_n);
  cov_cycle_c: cover property (seq_reg == thermal_status_pkg::SEQ_REMOTE2 && slot_end);
  cov_stall_c: cover property (fan_flags_reg[7]);
  cov_pin_c: cover property (comp_mode && ot_flags_reg[2] && o_alert_n);

endmodule : thermal_status_alert_logic

// ### tb/smbus_host_model.sv
// Host side of the register port: reads, writes and alert responses.
// Assumes a read answer arrives exactly one edge after the request.
`timescale 1ns/1ps
module smbus_host_model (
  // Clock and answers
  input  wire logic                    i_clk,
  input  wire logic                    i_rvalid,
  input  wire logic [7:0]              i_rdata,
  // Requests
  output thermal_status_pkg::reg_req_t o_req,
  output logic                         o_ack
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial begin
    o_req = '0;
    o_ack = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    o_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge i_clk) #1;
    o_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  // Polling is the host's alternative to servicing the alert line
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    o_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge i_clk) #1;
    o_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    // A missing answer reads as unknown, so the caller's compare trips
    d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
  endtask : rd
  task automatic ack();
    @(posedge i_clk) #1;
    o_ack = 1'b1;
    @(posedge i_clk) #1;
    o_ack = 1'b0;
  endtask : ack
endmodule : smbus_host_model

// ### tb/test_thermal_status_alert_logic.sv
// Self-checking bench for the thermal status and alert block.
// Assumes shortened conversion slots and the host model on the register port.
`timescale 1ns/1ps
module test_thermal_status_alert_logic;
  // ----------------------------------------------------------------
  // Stimulus and converter stand-in
  // ----------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1, tclk = 1'b0, trst = 1'b1, fan_a = 1'b0, fan_b = 1'b0;
  logic done = 1'b0, ack, rvalid, alert_n, oe, averaging, ot_pin = 1'b0, fan_alarm = 1'b0;
  logic [2:0] starts, last_start = 3'b000;
  logic [7:0] rdata, e;
  logic [7:0] v [3];
  logic       df [3];
  logic [1:0] ch = 2'd0;
  thermal_status_pkg::reg_req_t req;
  thermal_status_pkg::conv_result_t res = '0;
  integer seed = 12, err_total = 0, n_compared = 0, n_starts = 0, wait_c = 0, k;
  always #2 clk = ~clk;
  always #7.5 tclk = ~tclk;
  // Random fan_a and fan_b activity keeps both fans out of the stall state
  always @(posedge tclk) {fan_a, fan_b} <= 2'($random(seed));
  always @(posedge clk) begin
    done <= 1'b0;
    if (starts != 3'b000) begin
      ch <= starts[0] ? 2'd0 : (starts[1] ? 2'd1 : 2'd2);
      wait_c <= 5;
      n_starts <= n_starts + 1;
      last_start <= starts;
    end else if (wait_c > 0) begin
      wait_c <= wait_c - 1;
      done <= (wait_c == 1);
      res <= '{value: v[ch], diode_fault: df[ch]};
    end
  end
  thermal_status_alert_logic #(.LOCAL_CYCLES(20), .REMOTE_CYCLES(40), .FAN_A_TIMEOUT(50))
    i_thermal_status_alert_logic (.i_clk(clk), .i_sys_rst(rst), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_alert_response_done(ack), .o_conv_start(starts),
    .o_conv_average(averaging), .i_conv_done(done), .i_conv_result(res),
    .i_overtemp_pin(ot_pin), .i_overtemp_pct_exceeded(1'b0), .i_fan_alarm_speed(fan_alarm),
    .i_fan_a_clk(tclk), .i_fan_a_rst(trst), .i_fan_a(fan_a), .i_fan_b(fan_b), .o_alert_n(alert_n),
    .o_alert_oe(oe));
  smbus_host_model i_smbus_host_model (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata),
    .o_req(req), .o_ack(ack));
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [7:0] ex, input logic [7:0] got);
    n_compared++;
    if (got !== ex) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, ex, got);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] ex);
    logic [7:0] d;
    i_smbus_host_model.rd(a, d);
    chk("read", ex, d);
  endtask : rchk
  // Low drives the pin, so the enable must track it
  task automatic alert(input logic low);
    repeat (3) @(posedge clk);
    #1;
    chk("alert", low ? 8'h02 : 8'h01, {6'h00, oe, alert_n});
  endtask : alert
  task automatic settle();
    repeat (110) @(posedge clk);
  endtask : settle
  // In-limit values sit between the reset low and high limits
  task automatic calm();
    for (int c = 0; c < 3; c++) begin
      v[c] = 8'h54 + 8'($unsigned($random(seed)) % 55);
      df[c] = 1'b0;
    end
  endtask : calm
  function automatic logic [7:0] exp_s1();
    logic [7:0] hi, lo;
    hi = thermal_status_pkg::HIGH_LIMIT_RESET;
    lo = thermal_status_pkg::LOW_LIMIT_RESET;
    return {v[0] >= hi, v[0] < lo, v[1] >= hi, v[1] < lo, df[1], v[2] >= hi, v[2] < lo, df[2]};
  endfunction : exp_s1
  initial begin
    #400000;
    err_total++;
    conclude();
  end
  initial begin
    calm();
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    trst = 1'b0;
    settle();
    rchk(8'h01, thermal_status_pkg::CONFIG_ONE_RESET);
    chk("averaging", 8'h01, {7'h00, averaging});
    rchk(8'h4f, 8'h00);
    rchk(8'h50, 8'h00);
    rchk(8'h51, 8'h00);
    rchk(8'hff, 8'h00);
    alert(1'b0);
    v[0] = 8'h8b;
    v[1] = 8'h53;
    v[2] = 8'h54;
    df[1] = 1'b1;
    df[2] = 1'b1;
    e = exp_s1();
    settle();
    alert(1'b1);
    rchk(8'h51, 8'h01);
    calm();
    settle();
    alert(1'b1);
    rchk(8'h4f, e);
    rchk(8'h4f, 8'h00);
    alert(1'b0);
    v[2] = 8'h8b;
    settle();
    calm();
    settle();
    alert(1'b1);
    i_smbus_host_model.ack();
    alert(1'b0);
    rchk(8'h4f, 8'h00);
    i_smbus_host_model.wr(8'h08, 8'hff);
    v[0] = 8'h40;
    e = exp_s1();
    settle();
    alert(1'b0);
    rchk(8'h4f, e);
    i_smbus_host_model.wr(8'h08, 8'h00);
    alert(1'b1);
    calm();
    settle();
    rchk(8'h4f, e);
    alert(1'b0);
    i_smbus_host_model.wr(8'h01, 8'h09);
    v[0] = 8'h54;
    v[1] = 8'h90;
    e = exp_s1();
    settle();
    alert(1'b1);
    calm();
    settle();
    alert(1'b0);
    rchk(8'h4f, e);
    i_smbus_host_model.wr(8'h01, 8'h08);
    settle();
    settle();
    k = n_starts;
    settle();
    chk("starts", 8'h00, 8'(n_starts - k));
    i_smbus_host_model.wr(8'h01, 8'h09);
    k = n_starts;
    repeat (90) @(posedge clk);
    chk("starts", 8'h03, 8'(n_starts - k));
    chk("last", 8'h04, {5'h00, last_start});
    repeat (20) @(posedge clk);
    chk("last", 8'h01, {5'h00, last_start});
    #1 ot_pin = 1'b1;
    alert(1'b0);
    rchk(8'h50, 8'h04);
    i_smbus_host_model.wr(8'h01, 8'h01);
    alert(1'b1);
    ot_pin = 1'b0;
    alert(1'b1);
    rchk(8'h50, 8'h04);
    alert(1'b0);
    rchk(8'h50, 8'h00);
    fan_alarm = 1'b1;
    alert(1'b1);
    fan_alarm = 1'b0;
    rchk(8'h51, 8'h41);
    alert(1'b0);
    conclude();
  end
endmodule : test_thermal_status_alert_logic
